// ==== verilog/usf_flow_ctrl.sv ====
`timescale 1ns/1ps
module usf_flow_ctrl #(
    parameter int FIFO_DEPTH = 64
) (
    input wire logic CLK_SYS, // system clock
    input wire logic RESETN, // async reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb enable
    input wire logic PWRITE, // apb write
    input wire logic [7:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error, unmapped address
    input wire logic RX_VALID, // received character strobe
    input wire logic [7:0] RX_DATA, // received character
    input wire logic RX_ERR, // parity, framing or break
    input wire logic [6:0] RX_LEVEL, // receive fifo fill level
    output logic RXF_WRITE, // write strobe into receive fifo
    output logic [7:0] RXF_DATA, // data into receive fifo
    input wire logic TXF_VALID, // transmit fifo not empty
    input wire logic [7:0] TXF_DATA, // transmit fifo head
    output logic TXF_POP, // take head of transmit fifo
    input wire logic TX_READY, // transmitter at char boundary
    output logic TX_VALID, // character to transmitter
    output logic [7:0] TX_DATA, // character, word-length masked
    output logic TX_HALTED, // transmit held by a pause
    output logic PAUSE_IRQ // pause interrupt output
);
    if (FIFO_DEPTH < usf_pkg::THR_MAX_LEVEL || FIFO_DEPTH > 127)
    begin : g_depth_check
        $error("FIFO_DEPTH out of range");
    end

    usf_pkg::usf_state_t s;
    usf_pkg::usf_state_t s_next;
    usf_pkg::usf_chars_t c;
    usf_pkg::usf_chars_t c_next;
    usf_pkg::usf_match_t m;
    logic in_v;
    logic [7:0] in_d;
    logic in_e;
    logic acc;
    logic hit;
    logic [31:0] rd;
    logic [6:0] halt_lvl;
    logic [6:0] resume_lvl;
    logic pause_evt;
    logic resume_evt;
    logic store;
    logic [1:0] rx_mode;
    logic [1:0] tx_mode;

    function automatic logic [7:0] flow_pick(
        input usf_pkg::usf_chars_t ch,
        input logic [1:0] mode,
        input logic resume,
        input logic second
    );
        logic use_two;
        use_two = mode == usf_pkg::FC_TWO
            || (mode == usf_pkg::FC_BOTH && second);
        if (resume)
            flow_pick = use_two ? ch.resume_two : ch.resume_one;
        else
            flow_pick = use_two ? ch.pause_two : ch.pause_one;
    endfunction

    function automatic logic [7:0] wmask(
        input logic [7:0] d,
        input logic [1:0] wl
    );
        wmask = d & (8'hFF >> (usf_pkg::WLEN_MAX - wl));
    endfunction

    assign rx_mode = s.feature[1:0];
    assign tx_mode = s.feature[3:2];
    assign in_v = RX_VALID || s.replay_v;
    assign in_d = s.replay_v ? s.replay_d : RX_DATA;
    assign in_e = s.replay_v ? s.replay_err : RX_ERR;

    usf_char_match u_match (
        .data(in_d),
        .chars(c),
        .rx_mode(rx_mode),
        .tx_mode(tx_mode),
        .m(m)
    );

    // ********************************************************
    // next state
    // ********************************************************
    always_comb
    begin
        s_next = s;
        c_next = c;
        rd = '0;
        hit = 1'b1;
        pause_evt = 1'b0;
        resume_evt = 1'b0;
        store = 1'b0;
        halt_lvl = 7'(s.thresh[3:0]) << usf_pkg::THR_SHIFT;
        resume_lvl = 7'(s.thresh[7:4]) << usf_pkg::THR_SHIFT;

        // apb: ready one cycle into access, effect at completion
        acc = PSEL && PENABLE && s.pready;
        s_next.pready = PSEL && PENABLE && !s.pready;
        s_next.prdata = '0;
        s_next.pslverr = 1'b0;
        if (PSEL && PENABLE && !s.pready)
        begin
            if (PADDR == usf_pkg::OFS_FEATURE)
                rd = {24'h000000, s.feature};
            else if (PADDR == usf_pkg::OFS_MODEM)
                rd = {24'h000000, s.modem};
            else if (PADDR == usf_pkg::OFS_IRQ_EN)
                rd = {24'h000000, s.irq_en};
            else if (PADDR == usf_pkg::OFS_THRESH)
                rd = {24'h000000, s.thresh};
            else if (PADDR == usf_pkg::OFS_IDENT)
                rd = {24'h000000, s.flag ? usf_pkg::IDENT_PAUSE
                    : usf_pkg::IDENT_NONE};
            else if (PADDR == usf_pkg::OFS_RESUME_ONE)
                rd = {24'h000000, c.resume_one};
            else if (PADDR == usf_pkg::OFS_RESUME_TWO)
                rd = {24'h000000, c.resume_two};
            else if (PADDR == usf_pkg::OFS_PAUSE_ONE)
                rd = {24'h000000, c.pause_one};
            else if (PADDR == usf_pkg::OFS_PAUSE_TWO)
                rd = {24'h000000, c.pause_two};
            else if (PADDR == usf_pkg::OFS_LINE)
                rd = {30'h00000000, s.wlen};
            else if (PADDR == usf_pkg::OFS_STATUS)
                rd = {29'h00000000, s.rx_st != usf_pkg::RX_PLAIN,
                    s.pause_sent, s.halted};
            else
                hit = 1'b0;
            s_next.prdata = rd;
            s_next.pslverr = !hit;
        end
        if (acc && PWRITE)
        begin
            if (PADDR == usf_pkg::OFS_FEATURE)
                s_next.feature = PWDATA[7:0];
            else if (PADDR == usf_pkg::OFS_MODEM)
                s_next.modem = PWDATA[7:0];
            else if (PADDR == usf_pkg::OFS_IRQ_EN)
                s_next.irq_en = PWDATA[7:0];
            else if (PADDR == usf_pkg::OFS_THRESH)
                s_next.thresh = PWDATA[7:0];
            else if (PADDR == usf_pkg::OFS_RESUME_ONE)
                c_next.resume_one = PWDATA[7:0];
            else if (PADDR == usf_pkg::OFS_RESUME_TWO)
                c_next.resume_two = PWDATA[7:0];
            else if (PADDR == usf_pkg::OFS_PAUSE_ONE)
                c_next.pause_one = PWDATA[7:0];
            else if (PADDR == usf_pkg::OFS_PAUSE_TWO)
                c_next.pause_two = PWDATA[7:0];
            else if (PADDR == usf_pkg::OFS_LINE)
                s_next.wlen = PWDATA[1:0];
        end
        if (acc && !PWRITE && PADDR == usf_pkg::OFS_IDENT)
            s_next.flag = 1'b0;

        // ****************************************************
        // receive side
        // ****************************************************
        // a mismatched pair replays its second character next cycle
        s_next.replay_v = 1'b0;
        s_next.rxf_wr = 1'b0;
        s_next.rxf_d = in_d;
        if (in_v)
        begin
            if (s.rx_st != usf_pkg::RX_PLAIN)
            begin
                s_next.rx_st = usf_pkg::RX_PLAIN;
                if (!in_e && s.rx_st == usf_pkg::RX_HELD_PAUSE
                    && m.hit_p2)
                    pause_evt = 1'b1;
                else if (!in_e && s.rx_st == usf_pkg::RX_HELD_RESUME
                    && m.hit_r2)
                    resume_evt = 1'b1;
                else
                begin
                    s_next.rxf_wr = 1'b1;
                    s_next.rxf_d = s.held;
                    s_next.replay_v = 1'b1;
                    s_next.replay_d = in_d;
                    s_next.replay_err = in_e;
                end
            end
            else if (in_e || rx_mode == usf_pkg::FC_NONE)
                store = 1'b1;
            else if (s.halted && s.modem[usf_pkg::ANY_RESUME_BIT])
            begin
                resume_evt = 1'b1;
                store = m.seq_mode ? !m.hit_r1 : !m.single_resume;
            end
            else if (m.seq_mode && (m.hit_p1 || m.hit_r1))
            begin
                s_next.rx_st = m.hit_p1 ? usf_pkg::RX_HELD_PAUSE
                    : usf_pkg::RX_HELD_RESUME;
                s_next.held = in_d;
            end
            else if (m.single_pause)
                pause_evt = 1'b1;
            else if (m.single_resume)
                resume_evt = 1'b1;
            else
                store = 1'b1;
            if (store && !in_e && s.feature[usf_pkg::SPECIAL_BIT]
                && m.hit_p2)
                s_next.flag = 1'b1;
            if (store)
                s_next.rxf_wr = 1'b1;
        end
        if (resume_evt)
        begin
            s_next.halted = 1'b0;
            s_next.flag = 1'b0;
        end
        if (pause_evt)
        begin
            s_next.halted = 1'b1;
            s_next.flag = 1'b1;
        end
        if (rx_mode == usf_pkg::FC_NONE)
            s_next.halted = 1'b0;
        s_next.irq = s_next.flag && s_next.irq_en[usf_pkg::PAUSE_IRQ_BIT];

        // ****************************************************
        // transmit side
        // ****************************************************
        if (s.fs == usf_pkg::FS_IDLE)
        begin
            if (s.pause_sent)
            begin
                if (tx_mode != s.sent_mode || RX_LEVEL <= resume_lvl)
                begin
                    s_next.fs = usf_pkg::FS_FIRST;
                    s_next.fs_resume = 1'b1;
                    s_next.fs_mode = s.sent_mode;
                end
            end
            else if (tx_mode != usf_pkg::FC_NONE && RX_LEVEL > halt_lvl)
            begin
                s_next.fs = usf_pkg::FS_FIRST;
                s_next.fs_resume = 1'b0;
                s_next.fs_mode = tx_mode;
            end
        end
        s_next.tx_valid = 1'b0;
        s_next.pop = 1'b0;
        if (TX_READY && !s.tx_valid)
        begin
            if (s.fs != usf_pkg::FS_IDLE)
            begin
                s_next.tx_valid = 1'b1;
                s_next.tx_data = wmask(flow_pick(c, s.fs_mode, s.fs_resume,
                    s.fs == usf_pkg::FS_SECOND), s.wlen);
                if (s.fs == usf_pkg::FS_FIRST
                    && s.fs_mode == usf_pkg::FC_BOTH)
                    s_next.fs = usf_pkg::FS_SECOND;
                else
                begin
                    s_next.fs = usf_pkg::FS_IDLE;
                    s_next.pause_sent = !s.fs_resume;
                    s_next.sent_mode = s.fs_mode;
                end
            end
            else if (!s.halted && TXF_VALID)
            begin
                s_next.tx_valid = 1'b1;
                s_next.pop = 1'b1;
                s_next.tx_data = wmask(TXF_DATA, s.wlen);
            end
        end
    end

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s <= '0;
            s.wlen <= usf_pkg::WLEN_RST;
        end
        else
            s <= s_next;
    end

    // no reset: flow characters survive a device reset
    // characters kept
    always_ff @(posedge CLK_SYS)
    begin
        c <= c_next;
    end

    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign RXF_WRITE = s.rxf_wr;
    assign RXF_DATA = s.rxf_d;
    assign TXF_POP = s.pop;
    assign TX_VALID = s.tx_valid;
    assign TX_DATA = s.tx_data;
    assign TX_HALTED = s.halted;
    assign PAUSE_IRQ = s.irq;
endmodule

// ==== inc/usf_pkg.sv ====
package usf_pkg;
    // ********************************************************
    // register offsets (byte addresses, one word each)
    // ********************************************************
    localparam logic [7:0] OFS_FEATURE = 8'h00;
    localparam logic [7:0] OFS_MODEM = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFS_THRESH = 8'h0C;
    localparam logic [7:0] OFS_IDENT = 8'h10;
    localparam logic [7:0] OFS_RESUME_ONE = 8'h14;
    localparam logic [7:0] OFS_RESUME_TWO = 8'h18;
    localparam logic [7:0] OFS_PAUSE_ONE = 8'h1C;
    localparam logic [7:0] OFS_PAUSE_TWO = 8'h20;
    localparam logic [7:0] OFS_LINE = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;

    // ********************************************************
    // fields, codes and reset values
    // ********************************************************
    localparam int SPECIAL_BIT = 5;
    localparam int ANY_RESUME_BIT = 5;
    localparam int PAUSE_IRQ_BIT = 5;
    localparam logic [1:0] FC_NONE = 2'h0;
    localparam logic [1:0] FC_TWO = 2'h1;
    localparam logic [1:0] FC_ONE = 2'h2;
    localparam logic [1:0] FC_BOTH = 2'h3;
    localparam logic [7:0] IDENT_NONE = 8'h01;
    localparam logic [7:0] IDENT_PAUSE = 8'h10;
    localparam logic [1:0] WLEN_RST = 2'h1;
    localparam logic [1:0] WLEN_MAX = 2'h3;
    localparam int THR_SHIFT = 2;
    localparam int THR_MAX_LEVEL = 60;

    typedef struct packed {
        logic [7:0] pause_one;
        logic [7:0] pause_two;
        logic [7:0] resume_one;
        logic [7:0] resume_two;
    } usf_chars_t;

    typedef struct packed {
        logic hit_p1;
        logic hit_p2;
        logic hit_r1;
        logic hit_r2;
        logic single_pause;
        logic single_resume;
        logic seq_mode;
    } usf_match_t;

    typedef enum logic [1:0] {FS_IDLE, FS_FIRST, FS_SECOND} usf_fs_t;
    typedef enum logic [1:0] {RX_PLAIN, RX_HELD_PAUSE, RX_HELD_RESUME}
        usf_rx_t;

    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] modem;
        logic [7:0] irq_en;
        logic [7:0] thresh;
        logic [1:0] wlen;
        usf_rx_t rx_st;
        logic [7:0] held;
        logic replay_v;
        logic [7:0] replay_d;
        logic replay_err;
        logic halted;
        logic flag;
        logic irq;
        usf_fs_t fs;
        logic fs_resume;
        logic [1:0] fs_mode;
        logic pause_sent;
        logic [1:0] sent_mode;
        logic tx_valid;
        logic [7:0] tx_data;
        logic pop;
        logic rxf_wr;
        logic [7:0] rxf_d;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } usf_state_t;
endpackage

// ==== verilog/usf_char_match.sv ====
`timescale 1ns/1ps
// ************************************************************
// flow character comparator
// ************************************************************
module usf_char_match (
    input wire logic [7:0] data, // character under test
    input wire usf_pkg::usf_chars_t chars, // programmed characters
    input wire logic [1:0] rx_mode, // receive compare selection
    input wire logic [1:0] tx_mode, // transmit pair selection
    output usf_pkg::usf_match_t m // classification
);
    always_comb
    begin
        m = '0;
        m.hit_p1 = data == chars.pause_one;
        m.hit_p2 = data == chars.pause_two;
        m.hit_r1 = data == chars.resume_one;
        m.hit_r2 = data == chars.resume_two;
        m.seq_mode = rx_mode == usf_pkg::FC_BOTH
            && (tx_mode == usf_pkg::FC_BOTH
            || tx_mode == usf_pkg::FC_NONE);
        case (rx_mode)
            usf_pkg::FC_ONE:
            begin
                m.single_pause = m.hit_p1;
                m.single_resume = m.hit_r1;
            end
            usf_pkg::FC_TWO:
            begin
                m.single_pause = m.hit_p2;
                m.single_resume = m.hit_r2;
            end
            usf_pkg::FC_BOTH:
            begin
                m.single_pause = !m.seq_mode && (m.hit_p1 || m.hit_p2);
                m.single_resume = !m.seq_mode && (m.hit_r1 || m.hit_r2);
            end
            default:
            begin
                m.single_pause = 1'b0;
                m.single_resume = 1'b0;
            end
        endcase
    end
endmodule

// ==== sim/usf_flow_checker.sv ====
`timescale 1ns/1ps
// ********************************************************
// port checker
// ********************************************************
module usf_flow_checker (
    input logic CLK_SYS, // system clock
    input logic RESETN, // async reset, active low
    input logic PSEL, // apb select
    input logic PENABLE, // apb enable
    input logic PREADY, // apb ready
    input logic PSLVERR, // apb error
    input logic [31:0] PRDATA, // apb read data
    input logic RX_VALID, // received character strobe
    input logic RX_ERR, // line error with character
    input logic RXF_WRITE, // receive fifo write
    input logic TX_READY, // transmitter at boundary
    input logic TX_VALID, // character to transmitter
    input logic TXF_POP, // transmit fifo pop
    input logic TX_HALTED // transmit held by pause
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    sequence s_access;
        PSEL && PENABLE && !PREADY ##1 PREADY ##1 !PREADY;
    endsequence

    sequence s_rx_cause;
        $past(RX_VALID) || $past(RX_VALID, 2);
    endsequence

    a_apb_one_wait: assert property ($rose(PSEL) && !PENABLE |=> s_access)
        else $error("apb answer not after one wait state");
    a_slverr_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("slave error outside ready cycle");
    a_rdata_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data not zero while idle");
    a_tx_single_pulse: assert property (TX_VALID |=> !TX_VALID)
        else $error("transmit strobe longer than one cycle");
    a_tx_at_boundary: assert property (TX_VALID |-> $past(TX_READY))
        else $error("character issued without ready transmitter");
    a_halt_blocks_pop: assert property (
        TX_HALTED && $past(TX_HALTED) |-> !TXF_POP)
        else $error("fifo byte taken while halted");
    a_halt_from_rx: assert property ($rose(TX_HALTED) |-> s_rx_cause)
        else $error("halt without received character");
    a_resume_cause: assert property ($fell(TX_HALTED) |->
        s_rx_cause or $past(PREADY) or $past(PREADY, 2))
        else $error("halt released without cause");
    a_err_char_stored: assert property (
        RX_VALID && RX_ERR |=> ##[0:1] RXF_WRITE)
        else $error("errored character not stored");
endmodule

bind usf_flow_ctrl usf_flow_checker chk_i (.CLK_SYS, .RESETN, .PSEL,
    .PENABLE, .PREADY, .PSLVERR, .PRDATA, .RX_VALID, .RX_ERR, .RXF_WRITE,
    .TX_READY, .TX_VALID, .TXF_POP, .TX_HALTED);

// ==== sim/usf_peer_model.sv ====
`timescale 1ns/1ps
// ********************************************************
// transmitter model: busy for one character per strobe
// ********************************************************
module usf_peer_model #(
    parameter int CHAR_CYC = 8
) (
    input logic clk, // system clock
    input logic rst_n, // async reset, active low
    input logic tx_valid, // character strobe
    input logic slow, // stretch character time
    output logic tx_ready // idle at boundary
);
    int cnt;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 0;
            tx_ready <= 1'b0;
        end
        else if (tx_valid)
        begin
            tx_ready <= 1'b0;
            cnt <= slow ? 3 * CHAR_CYC : CHAR_CYC;
        end
        else if (cnt != 0)
            cnt <= cnt - 1;
        else
            tx_ready <= 1'b1;
    end
endmodule

// ==== sim/tb_usf_flow_ctrl.sv ====
`timescale 1ns/1ps
module tb_usf_flow_ctrl;
    logic CLK_SYS = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
    logic PWRITE = 1'b0, RX_VALID = 1'b0, RX_ERR = 1'b0, slow = 1'b0;
    logic TXF_VALID = 1'b0;
    logic [7:0] PADDR = 8'h00, RX_DATA = 8'h00, TXF_DATA = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [6:0] RX_LEVEL = 7'h00;
    logic [31:0] PRDATA, rd;
    logic PREADY, PSLVERR, RXF_WRITE, TXF_POP, TX_READY, TX_VALID;
    logic TX_HALTED, PAUSE_IRQ, last_err;
    logic [7:0] RXF_DATA, TX_DATA;
    logic [7:0] rxq[$], txq[$];
    int err_count = 0, checked = 0, pops = 0;
    localparam logic [7:0] R1 = 8'h11, R2 = 8'h13, P1 = 8'h39, P2 = 8'h17;

    always #50 CLK_SYS = ~CLK_SYS;

    usf_flow_ctrl dut (.CLK_SYS, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RX_VALID, .RX_DATA, .RX_ERR,
        .RX_LEVEL, .RXF_WRITE, .RXF_DATA, .TXF_VALID, .TXF_DATA, .TXF_POP,
        .TX_READY, .TX_VALID, .TX_DATA, .TX_HALTED, .PAUSE_IRQ);
    usf_peer_model #(.CHAR_CYC(8)) peer (.clk(CLK_SYS), .rst_n(RESETN),
        .tx_valid(TX_VALID), .slow(slow), .tx_ready(TX_READY));

    // output logs and pop count
    always @(posedge CLK_SYS)
    begin
        if (RXF_WRITE === 1'b1)
            rxq.push_back(RXF_DATA);
        if (TX_VALID === 1'b1)
            txq.push_back(TX_DATA);
        if (TXF_POP === 1'b1)
            pops++;
    end

    task give_verdict;
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLK_SYS);
            n++;
        end
        while (PREADY !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            err_count++;
            give_verdict;
        end
        rd = PRDATA;
        last_err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task rx(input logic [7:0] d, input logic e);
        @(posedge CLK_SYS);
        RX_VALID <= 1'b1;
        RX_DATA <= d;
        RX_ERR <= e;
        @(posedge CLK_SYS);
        RX_VALID <= 1'b0;
        RX_ERR <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
    endtask

    task automatic take(ref logic [7:0] q[$], input logic [7:0] exp);
        int n;
        n = 0;
        while (q.size() == 0 && n < 300)
        begin
            @(posedge CLK_SYS);
            n++;
        end
        if (q.size() == 0)
        begin
            err_count++;
            give_verdict;
        end
        chk(32'(q.pop_front()), 32'(exp));
    endtask

    task flags(input logic h, input logic i);
        chk(32'(TX_HALTED), 32'(h));
        chk(32'(PAUSE_IRQ), 32'(i));
    endtask

    initial
    begin
        repeat (5) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        @(posedge CLK_SYS);
        rd_chk(usf_pkg::OFS_FEATURE, 32'h0);
        rd_chk(usf_pkg::OFS_THRESH, 32'h0);
        rd_chk(usf_pkg::OFS_IDENT, 32'h1);
        rd_chk(8'h3C, 32'h0);
        chk(32'(last_err), 32'h1);
        apb(1'b1, usf_pkg::OFS_LINE, 32'h3);
        apb(1'b1, usf_pkg::OFS_RESUME_ONE, 32'(R1));
        apb(1'b1, usf_pkg::OFS_RESUME_TWO, 32'(R2));
        apb(1'b1, usf_pkg::OFS_PAUSE_ONE, 32'(P1));
        apb(1'b1, usf_pkg::OFS_PAUSE_TWO, 32'(P2));
        apb(1'b1, usf_pkg::OFS_IRQ_EN, 32'h20);
        apb(1'b1, usf_pkg::OFS_FEATURE, 32'h02);
        rx(P1, 1'b0);
        flags(1'b1, 1'b1);
        TXF_VALID <= 1'b1;
        TXF_DATA <= 8'h5A;
        repeat (30) @(posedge CLK_SYS);
        chk(32'(txq.size()), 32'h0);
        rd_chk(usf_pkg::OFS_IDENT, 32'h10);
        repeat (2) @(posedge CLK_SYS);
        flags(1'b1, 1'b0);
        rx(R1, 1'b0);
        flags(1'b0, 1'b0);
        take(txq, 8'h5A);
        // one-entry fifo is empty after its pop
        TXF_VALID <= 1'b0;
        rx(P1, 1'b1);
        flags(1'b0, 1'b0);
        take(rxq, P1);
        apb(1'b1, usf_pkg::OFS_FEATURE, 32'h0F);
        rx(P1, 1'b0);
        rx(P2, 1'b0);
        flags(1'b1, 1'b1);
        chk(32'(rxq.size()), 32'h0);
        rx(R1, 1'b0);
        rx(R2, 1'b0);
        flags(1'b0, 1'b0);
        rx(P1, 1'b0);
        rx(8'h41, 1'b0);
        take(rxq, P1);
        take(rxq, 8'h41);
        apb(1'b1, usf_pkg::OFS_FEATURE, 32'h0B);
        rx(P2, 1'b0);
        chk(32'(TX_HALTED), 32'h1);
        rx(R1, 1'b0);
        chk(32'(TX_HALTED), 32'h0);
        apb(1'b1, usf_pkg::OFS_FEATURE, 32'h20);
        rx(P2, 1'b0);
        take(rxq, P2);
        flags(1'b0, 1'b1);
        rd_chk(usf_pkg::OFS_IDENT, 32'h10);
        rd_chk(usf_pkg::OFS_IDENT, 32'h1);
        apb(1'b1, usf_pkg::OFS_FEATURE, 32'h02);
        apb(1'b1, usf_pkg::OFS_MODEM, 32'h20);
        rx(P1, 1'b0);
        rx(8'h41, 1'b0);
        chk(32'(TX_HALTED), 32'h0);
        take(rxq, 8'h41);
        apb(1'b1, usf_pkg::OFS_MODEM, 32'h0);
        apb(1'b1, usf_pkg::OFS_FEATURE, 32'h01);
        rx(P1, 1'b0);
        take(rxq, P1);
        rx(P2, 1'b0);
        chk(32'(TX_HALTED), 32'h1);
        rx(R2, 1'b0);
        chk(32'(TX_HALTED), 32'h0);
        apb(1'b1, usf_pkg::OFS_LINE, 32'h0);
        // resume level below halt level: above halt only a mode change resumes
        apb(1'b1, usf_pkg::OFS_THRESH, 32'h12);
        apb(1'b1, usf_pkg::OFS_FEATURE, 32'h08);
        RX_LEVEL <= 7'h08;
        repeat (20) @(posedge CLK_SYS);
        chk(32'(txq.size()), 32'h0);
        RX_LEVEL <= 7'h09;
        take(txq, 8'h19);
        RX_LEVEL <= 7'h04;
        take(txq, R1);
        slow <= 1'b1;
        RX_LEVEL <= 7'h09;
        take(txq, 8'h19);
        apb(1'b1, usf_pkg::OFS_FEATURE, 32'h0);
        take(txq, R1);
        apb(1'b1, usf_pkg::OFS_FEATURE, 32'h08);
        take(txq, 8'h19);
        apb(1'b1, usf_pkg::OFS_FEATURE, 32'h04);
        take(txq, R1);
        take(txq, P2);
        RX_LEVEL <= 7'h00;
        take(txq, R2);
        apb(1'b1, usf_pkg::OFS_FEATURE, 32'h0C);
        RX_LEVEL <= 7'h09;
        take(txq, 8'h19);
        take(txq, P2);
        RX_LEVEL <= 7'h00;
        take(txq, R1);
        take(txq, R2);
        chk(32'(rxq.size()), 32'h0);
        chk(32'(txq.size()), 32'h0);
        chk(pops, 1);
        RESETN <= 1'b0;
        repeat (5) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        @(posedge CLK_SYS);
        rd_chk(usf_pkg::OFS_PAUSE_ONE, 32'(P1));
        rd_chk(usf_pkg::OFS_THRESH, 32'h0);
        give_verdict;
    end
endmodule
